/* rtl/adcwd_pkg.sv */
// Purpose: constants and types of the converter watchdog and irq flags
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   flag vectors are kept packed as six bits inside the block
package adcwd_pkg;

	// register byte offsets
	localparam logic [11:0] OFS_WD_CTRL   = 12'h078;
	localparam logic [11:0] OFS_WD_LIMITS = 12'h07c;
	localparam logic [11:0] OFS_IRQ_EN    = 12'h080;
	localparam logic [11:0] OFS_IRQ_RAW   = 12'h084;
	localparam logic [11:0] OFS_IRQ_MASK  = 12'h088;
	localparam logic [11:0] OFS_IRQ_CLR   = 12'h08c;

	// common reset value of every register
	localparam logic [31:0] RST_VALUE = 32'h0000_0000;

	// watchdog limits field positions
	localparam int UPPER_LSB = 16;
	localparam int LOWER_LSB = 0;
	localparam int LIMIT_W   = 12;

	// watchdog control field positions
	localparam int UCH_LSB   = 24;
	localparam int LCH_LSB   = 16;
	localparam int WCH_LSB   = 8;
	localparam int WALL_BIT  = 2;
	localparam int WUE_BIT   = 1;
	localparam int WLE_BIT   = 0;
	localparam int CH_W      = 4;

	// internal event index to register bit position
	localparam int NUM_SRC   = 6;
	localparam int SRC_SINGLE = 0;
	localparam int SRC_GROUP  = 1;
	localparam int SRC_CYCLE  = 2;
	localparam int SRC_LOWER  = 3;
	localparam int SRC_UPPER  = 4;
	localparam int SRC_OVWR   = 5;
	localparam int FLAG_POS [NUM_SRC] = '{0, 1, 2, 16, 17, 24};

	// ahb transfer type bit that marks an active transfer
	localparam int HTRANS_ACT = 1;

	// one stored conversion result from the sequencer
	typedef struct packed {
		logic        stb;   // result is being stored now
		logic [2:0]  slot;  // data slot being written
		logic [3:0]  chan;  // converted channel
		logic [11:0] data;  // converted value
	} adcwd_result_s;

endpackage

/* rtl/adcwd_top.sv */
// Purpose: watchdog limits, event flags and irq of the converter
// Assumes: AHB-Lite slave, zero wait states, word transfers only
// Notes:   events are one-cycle strobes from sequencer and data logic

// Functional notes
// - upper limit is 12 bits at limits[27:16], read-write, resets to 0
// - lower limit is 12 bits at limits[11:0], read-write, resets to 0
// - enable bits 24,17,16,2,1,0, one per source, 1 enables
// - raw flag sets on its event whatever its enable bit says
// - masked flag sets only when event occurs with enable at 1
// - masked flag reads 0 while its enable bit is 0
// - overwrite sets raw flag and masked flag if enabled
// - result above upper limit sets the upper-hit raw flag
// - result below lower limit sets the lower-hit raw flag
// - single, subgroup and cycle completion each set their own flag
// - writing 1 to a clear bit clears raw and masked flag
// - clear bits fall back to 0 by themselves, reset to 0
// - writing 0 to a clear bit changes no flag
// - upper check only with upper monitor on, lower likewise
// - all channels watched if all-channel bit set, else selected one
// - channel of last upper hit and last lower hit are recorded
module adcwd_top #(
	parameter int NUM_SLOTS = 8
) (
	input  wire logic                      SYS_CLK_I,
	input  wire logic                      RST_N_I,
	// ahb-lite slave
	input  wire logic                      HSEL_I,
	input  wire logic [31:0]               HADDR_I,
	input  wire logic [1:0]                HTRANS_I,
	input  wire logic                      HWRITE_I,
	input  wire logic [2:0]                HSIZE_I,
	input  wire logic [31:0]               HWDATA_I,
	input  wire logic                      HREADY_I,
	output logic      [31:0]               HRDATA_O,
	output logic                           HREADYOUT_O,
	output logic                           HRESP_O,
	// converter side
	input  wire adcwd_pkg::adcwd_result_s  RESULT_I,
	input  wire logic [NUM_SLOTS-1:0]      RESULT_VALID_FLAG_I,
	input  wire logic                      SINGLE_DONE_I,
	input  wire logic                      GROUP_DONE_I,
	input  wire logic                      CYCLE_DONE_I,
	output logic                           IRQ_O
);

	localparam int NS = adcwd_pkg::NUM_SRC;
	localparam int LW = adcwd_pkg::LIMIT_W;
	localparam int CW = adcwd_pkg::CH_W;

	// bus phase state
	logic           wr_pend_q;
	logic [11:0]    wr_addr_q;
	logic [31:0]    rdata_q;
	logic           addr_ok;

	// software state
	logic [LW-1:0]  upper_limit_q;
	logic [LW-1:0]  lower_limit_q;
	logic [NS-1:0]  irq_en_q;
	logic [NS-1:0]  clr_q;
	logic           upper_monitor_en_q;
	logic           lower_monitor_en_q;
	logic           monitor_all_channels_q;
	logic [CW-1:0]  monitored_channel_sel_q;

	// hardware state
	logic [NS-1:0]  raw_q;
	logic [NS-1:0]  masked_q;
	logic [CW-1:0]  upper_hit_channel_q;
	logic [CW-1:0]  lower_hit_channel_q;

	// event terms
	logic           watched;
	logic           upper_hit;
	logic           lower_hit;
	logic           overwrite;
	logic [NS-1:0]  event_v;
	logic [NS-1:0]  wr_en_v;
	logic [NS-1:0]  wr_clr_v;
	logic [NS-1:0]  visible_masked;
	logic [31:0]    rd_mux;
	logic           wr_now;
	logic           slot_unread;

	// decoded write data phases
	logic           wr_ctrl;
	logic           wr_limits;
	logic           wr_irq_en;
	logic           wr_irq_clr;

	// read views: writes and clears that land at this edge
	logic [LW-1:0]  upper_limit_d;
	logic [LW-1:0]  lower_limit_d;
	logic [NS-1:0]  irq_en_d;
	logic           upper_monitor_en_d;
	logic           lower_monitor_en_d;
	logic           monitor_all_channels_d;
	logic [CW-1:0]  monitored_channel_sel_d;
	logic [NS-1:0]  clr_pend;
	logic [NS-1:0]  rd_raw;
	logic [NS-1:0]  rd_masked;

	// address phase accepted on the bus
	assign addr_ok = HSEL_I & HREADY_I & HTRANS_I[adcwd_pkg::HTRANS_ACT];

	// zero wait states, always OKAY
	assign HREADYOUT_O = 1'b1;
	assign HRESP_O     = 1'b0;
	assign HRDATA_O    = rdata_q;

	// write data phase happens one cycle after its address phase
	assign wr_now = wr_pend_q;

	// write data phase decoded per register
	assign wr_ctrl    = wr_now & (wr_addr_q == adcwd_pkg::OFS_WD_CTRL);
	assign wr_limits  = wr_now & (wr_addr_q == adcwd_pkg::OFS_WD_LIMITS);
	assign wr_irq_en  = wr_now & (wr_addr_q == adcwd_pkg::OFS_IRQ_EN);
	assign wr_irq_clr = wr_now & (wr_addr_q == adcwd_pkg::OFS_IRQ_CLR);

	// unpack six-bit vectors from the word at their bit positions
	for (genvar i = 0; i < NS; i++) begin : g_unpack
		assign wr_en_v[i]  = HWDATA_I[adcwd_pkg::FLAG_POS[i]];
		assign wr_clr_v[i] = HWDATA_I[adcwd_pkg::FLAG_POS[i]];
	end

	// channel filter of the watchdog
	assign watched = monitor_all_channels_q |
		(RESULT_I.chan == monitored_channel_sel_q);

	// threshold comparison, each side gated by its monitor enable
	assign upper_hit = RESULT_I.stb & watched & upper_monitor_en_q &
		(RESULT_I.data > upper_limit_q);
	assign lower_hit = RESULT_I.stb & watched & lower_monitor_en_q &
		(RESULT_I.data < lower_limit_q);

	// unread flag of the slot being written; slots past the array are empty
	always_comb begin
		slot_unread = 1'b0;
		for (int s = 0; s < NUM_SLOTS; s++) begin
			if (int'(RESULT_I.slot) == s) begin
				slot_unread = RESULT_VALID_FLAG_I[s];
			end
		end
	end

	// storing into a slot whose unread data is still valid
	assign overwrite = RESULT_I.stb & slot_unread;

	// gather all event strobes in internal index order
	always_comb begin
		event_v = '0;
		event_v[adcwd_pkg::SRC_SINGLE] = SINGLE_DONE_I;
		event_v[adcwd_pkg::SRC_GROUP]  = GROUP_DONE_I;
		event_v[adcwd_pkg::SRC_CYCLE]  = CYCLE_DONE_I;
		event_v[adcwd_pkg::SRC_LOWER]  = lower_hit;
		event_v[adcwd_pkg::SRC_UPPER]  = upper_hit;
		event_v[adcwd_pkg::SRC_OVWR]   = overwrite;
	end

	// masked flags read as zero while their enable is off
	assign visible_masked = masked_q & irq_en_q;

	// level interrupt from any visible masked flag
	assign IRQ_O = |visible_masked;

	// per-source sticky flags, set beats clear
	for (genvar i = 0; i < NS; i++) begin : g_flag
		always_ff @(posedge SYS_CLK_I) begin
			if (!RST_N_I) begin
				raw_q[i]    <= 1'b0;
				masked_q[i] <= 1'b0;
			end else if (event_v[i]) begin
				raw_q[i] <= 1'b1;
				if (irq_en_q[i]) begin
					masked_q[i] <= 1'b1;
				end else if (clr_q[i]) begin
					masked_q[i] <= 1'b0;
				end
			end else if (clr_q[i]) begin
				raw_q[i]    <= 1'b0;
				masked_q[i] <= 1'b0;
			end
		end
	end

	// channel numbers of the latest limit hits
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			upper_hit_channel_q <= '0;
			lower_hit_channel_q <= '0;
		end else begin
			if (upper_hit) begin
				upper_hit_channel_q <= RESULT_I.chan;
			end
			if (lower_hit) begin
				lower_hit_channel_q <= RESULT_I.chan;
			end
		end
	end

	// address phase capture of a pending write
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
		end else begin
			wr_pend_q <= addr_ok & HWRITE_I;
			if (addr_ok) begin
				wr_addr_q <= HADDR_I[11:0];
			end
		end
	end

	// watchdog limits register
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			upper_limit_q <= adcwd_pkg::RST_VALUE[LW-1:0];
			lower_limit_q <= adcwd_pkg::RST_VALUE[LW-1:0];
		end else if (wr_now &&
			wr_addr_q == adcwd_pkg::OFS_WD_LIMITS) begin
			upper_limit_q <= HWDATA_I[adcwd_pkg::UPPER_LSB +: LW];
			lower_limit_q <= HWDATA_I[adcwd_pkg::LOWER_LSB +: LW];
		end
	end

	// watchdog control register, writable part
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			upper_monitor_en_q      <= 1'b0;
			lower_monitor_en_q      <= 1'b0;
			monitor_all_channels_q  <= 1'b0;
			monitored_channel_sel_q <= '0;
		end else if (wr_now &&
			wr_addr_q == adcwd_pkg::OFS_WD_CTRL) begin
			upper_monitor_en_q <= HWDATA_I[adcwd_pkg::WUE_BIT];
			lower_monitor_en_q <= HWDATA_I[adcwd_pkg::WLE_BIT];
			monitor_all_channels_q <= HWDATA_I[adcwd_pkg::WALL_BIT];
			monitored_channel_sel_q <=
				HWDATA_I[adcwd_pkg::WCH_LSB +: CW];
		end
	end

	// interrupt enable register
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			irq_en_q <= adcwd_pkg::RST_VALUE[NS-1:0];
		end else if (wr_now &&
			wr_addr_q == adcwd_pkg::OFS_IRQ_EN) begin
			irq_en_q <= wr_en_v;
		end
	end

	// self-clearing clear bits, live for exactly one cycle
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			clr_q <= adcwd_pkg::RST_VALUE[NS-1:0];
		end else if (wr_now &&
			wr_addr_q == adcwd_pkg::OFS_IRQ_CLR) begin
			clr_q <= wr_clr_v;
		end else begin
			clr_q <= '0;
		end
	end

	// next values of the software registers, so that a read pipelined
	// right behind a write returns the value just written
	always_comb begin
		upper_limit_d           = upper_limit_q;
		lower_limit_d           = lower_limit_q;
		irq_en_d                = irq_en_q;
		upper_monitor_en_d      = upper_monitor_en_q;
		lower_monitor_en_d      = lower_monitor_en_q;
		monitor_all_channels_d  = monitor_all_channels_q;
		monitored_channel_sel_d = monitored_channel_sel_q;
		if (wr_limits) begin
			upper_limit_d = HWDATA_I[adcwd_pkg::UPPER_LSB +: LW];
			lower_limit_d = HWDATA_I[adcwd_pkg::LOWER_LSB +: LW];
		end
		if (wr_ctrl) begin
			upper_monitor_en_d      = HWDATA_I[adcwd_pkg::WUE_BIT];
			lower_monitor_en_d      = HWDATA_I[adcwd_pkg::WLE_BIT];
			monitor_all_channels_d  = HWDATA_I[adcwd_pkg::WALL_BIT];
			monitored_channel_sel_d = HWDATA_I[adcwd_pkg::WCH_LSB +: CW];
		end
		if (wr_irq_en) begin
			irq_en_d = wr_en_v;
		end
	end

	// clears about to land hide their flags from a read
	assign clr_pend  = clr_q | (wr_irq_clr ? wr_clr_v : '0);
	assign rd_raw    = raw_q & ~clr_pend;
	assign rd_masked = masked_q & irq_en_d & ~clr_pend;

	// read multiplexer, sampled at the address phase
	always_comb begin
		rd_mux = '0;
		case (HADDR_I[11:0])
			adcwd_pkg::OFS_WD_CTRL: begin
				rd_mux[adcwd_pkg::UCH_LSB +: CW] = upper_hit_channel_q;
				rd_mux[adcwd_pkg::LCH_LSB +: CW] = lower_hit_channel_q;
				rd_mux[adcwd_pkg::WCH_LSB +: CW] =
					monitored_channel_sel_d;
				rd_mux[adcwd_pkg::WALL_BIT] = monitor_all_channels_d;
				rd_mux[adcwd_pkg::WUE_BIT]  = upper_monitor_en_d;
				rd_mux[adcwd_pkg::WLE_BIT]  = lower_monitor_en_d;
			end
			adcwd_pkg::OFS_WD_LIMITS: begin
				rd_mux[adcwd_pkg::UPPER_LSB +: LW] = upper_limit_d;
				rd_mux[adcwd_pkg::LOWER_LSB +: LW] = lower_limit_d;
			end
			adcwd_pkg::OFS_IRQ_EN: begin
				for (int i = 0; i < NS; i++) begin
					rd_mux[adcwd_pkg::FLAG_POS[i]] = irq_en_d[i];
				end
			end
			adcwd_pkg::OFS_IRQ_RAW: begin
				for (int i = 0; i < NS; i++) begin
					rd_mux[adcwd_pkg::FLAG_POS[i]] = rd_raw[i];
				end
			end
			adcwd_pkg::OFS_IRQ_MASK: begin
				for (int i = 0; i < NS; i++) begin
					rd_mux[adcwd_pkg::FLAG_POS[i]] = rd_masked[i];
				end
			end
			default: begin
				rd_mux = '0; // clear register and holes read zero
			end
		endcase
	end

	// read data register, valid through the data phase
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			rdata_q <= '0;
		end else if (addr_ok && !HWRITE_I) begin
			rdata_q <= rd_mux;
		end
	end

endmodule

/* test/adcwd_chk.sv */
// Purpose: concurrent checks on irq and bus answers of adcwd_top
// Assumes: enable register is shadowed from observed bus writes
// Notes:   flag bits 24,17,16,2,1,0
module adcwd_chk #(
	parameter int NUM_SLOTS = 8
) (
	input wire logic                     SYS_CLK_I,
	input wire logic                     RST_N_I,
	input wire logic                     HSEL_I,
	input wire logic [31:0]              HADDR_I,
	input wire logic [1:0]               HTRANS_I,
	input wire logic                     HWRITE_I,
	input wire logic [31:0]              HWDATA_I,
	input wire logic                     HREADY_I,
	input wire logic [31:0]              HRDATA_O,
	input wire logic                     IRQ_O,
	input wire adcwd_pkg::adcwd_result_s RESULT_I,
	input wire logic [NUM_SLOTS-1:0]     RESULT_VALID_FLAG_I,
	input wire logic                     SINGLE_DONE_I,
	input wire logic                     GROUP_DONE_I,
	input wire logic                     CYCLE_DONE_I
);
	logic        dwr_q;
	logic        dwr1_q;
	logic [11:0] adr_q;
	logic [31:0] en_q;
	wire         take = HSEL_I && HREADY_I && HTRANS_I[1];
	wire         ovw = RESULT_I.stb && RESULT_VALID_FLAG_I[RESULT_I.slot];
	wire         any_ev = RESULT_I.stb || SINGLE_DONE_I || GROUP_DONE_I ||
		CYCLE_DONE_I;
	// tracks write data phases and shadows the enable register
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			dwr_q  <= 1'b0;
			dwr1_q <= 1'b0;
			adr_q  <= 12'h000;
			en_q   <= 32'h0000_0000;
		end else begin
			dwr_q  <= take && HWRITE_I;
			dwr1_q <= dwr_q;
			adr_q  <= HADDR_I[11:0];
			if (dwr_q && adr_q == adcwd_pkg::OFS_IRQ_EN)
				en_q <= HWDATA_I & 32'h0103_0007;
		end
	end
	default clocking @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RST_N_I);
	sequence s_rd(logic [11:0] a);
		take && !HWRITE_I && HADDR_I[11:0] == a;
	endsequence
	// full clear write, then a quiet cycle while the clear pulse applies
	sequence s_clr_all;
		dwr_q && adr_q == adcwd_pkg::OFS_IRQ_CLR && HWDATA_I == 32'h0103_0007
		##1 !any_ev;
	endsequence
	// irq answers done and overwrite events, enables and clears; clear and enable registers read back
	AST_IRQ_SGL: assert property (SINGLE_DONE_I && en_q[0] && !dwr_q
		|=> IRQ_O) else $error("irq low after enabled single done");
	AST_IRQ_GRP: assert property (GROUP_DONE_I && en_q[1] && !dwr_q
		|=> IRQ_O) else $error("irq low after enabled group done");
	AST_IRQ_CYC: assert property (CYCLE_DONE_I && en_q[2] && !dwr_q
		|=> IRQ_O) else $error("irq low after enabled cycle done");
	AST_IRQ_OVW: assert property (ovw && en_q[24] && !dwr_q
		|=> IRQ_O) else $error("irq low after enabled overwrite");
	AST_IRQ_OFF: assert property (en_q == 32'h0 |-> !IRQ_O)
		else $error("irq high with all sources disabled");
	AST_IRQ_HOLD: assert property (IRQ_O && !dwr_q && !dwr1_q
		|=> IRQ_O) else $error("irq dropped without any write");
	AST_CLR_ALL: assert property (s_clr_all |=> !IRQ_O)
		else $error("irq still high after full clear");
	AST_CLR_RD0: assert property (s_rd(adcwd_pkg::OFS_IRQ_CLR)
		|=> HRDATA_O == 32'h0) else $error("clear register reads nonzero");
	AST_EN_RD: assert property (s_rd(adcwd_pkg::OFS_IRQ_EN)
		|=> HRDATA_O == en_q) else $error("enable readback wrong");
endmodule

bind adcwd_top adcwd_chk #(.NUM_SLOTS(NUM_SLOTS)) adcwd_chk_inst (
	.SYS_CLK_I, .RST_N_I, .HSEL_I, .HADDR_I, .HTRANS_I, .HWRITE_I,
	.HWDATA_I, .HREADY_I, .HRDATA_O, .IRQ_O, .RESULT_I,
	.RESULT_VALID_FLAG_I, .SINGLE_DONE_I, .GROUP_DONE_I, .CYCLE_DONE_I
);

/* test/testbench.sv */
// Purpose: self-checking bench for adcwd_top
// Assumes: zero wait states, single word transfers
// Notes:   every result is stored into slot 0
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] CTL = adcwd_pkg::OFS_WD_CTRL;
	localparam logic [11:0] LIM = adcwd_pkg::OFS_WD_LIMITS;
	localparam logic [11:0] EN  = adcwd_pkg::OFS_IRQ_EN;
	localparam logic [11:0] RAW = adcwd_pkg::OFS_IRQ_RAW;
	localparam logic [11:0] MSK = adcwd_pkg::OFS_IRQ_MASK;
	localparam logic [11:0] CLR = adcwd_pkg::OFS_IRQ_CLR;
	localparam logic [31:0] ALL = 32'h0103_0007;
	logic                     clk, rst_n, hwrite, hready, hresp, irq;
	logic [1:0]               htrans;
	logic [2:0]               done;
	logic [7:0]               vld;
	logic [31:0]              haddr, hwdata, hrdata;
	adcwd_pkg::adcwd_result_s res;
	int                       fails, num_checks;
	adcwd_top adcwd_top_inst (
		.SYS_CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(1'b1), .HADDR_I(haddr),
		.HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
		.HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
		.HREADYOUT_O(hready), .HRESP_O(hresp), .RESULT_I(res),
		.RESULT_VALID_FLAG_I(vld), .SINGLE_DONE_I(done[0]),
		.GROUP_DONE_I(done[1]), .CYCLE_DONE_I(done[2]), .IRQ_O(irq)
	);
	// clock of 10 ns period
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic test_done;
		if (fails == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			fails++;
		end
	endtask
	// one single transfer: address phase, then data phase
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		htrans <= 2'h2;
		haddr  <= {20'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(hrdata, exp);
		chk({31'h0, hresp}, 32'h0);
	endtask
	task automatic ev(input logic [2:0] d);
		done <= d;
		@(posedge clk);
		done <= 3'h0;
		@(posedge clk);
	endtask
	// stores one result into slot 0, v marks the slot as unread
	task automatic rs(input logic [3:0] c, input logic [11:0] d,
		input logic v);
		res <= {1'b1, 3'h0, c, d};
		vld <= {7'h0, v};
		@(posedge clk);
		res.stb <= 1'b0;
		vld     <= 8'h0;
		@(posedge clk);
	endtask
	// hang guard
	initial begin
		#20000;
		fails++;
		test_done;
	end
	// main sequence
	initial begin
		{rst_n, hwrite, htrans, haddr, hwdata, done, vld} = '0;
		res = '0;
		fails = 0;
		num_checks = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 6; i++)
			rd(CTL + 12'(4 * i), 32'h0);
		rd(12'h0f0, 32'h0);
		xfer(1'b1, LIM, '1);
		rd(LIM, 32'h0fff_0fff);
		xfer(1'b1, EN, '1);
		rd(EN, ALL);
		xfer(1'b1, EN, 32'h0);
		ev(3'h7);
		rd(RAW, 32'h7);
		rd(MSK, 32'h0);
		xfer(1'b1, EN, ALL);
		rd(MSK, 32'h0);
		xfer(1'b1, CLR, 32'h0);
		rd(RAW, 32'h7);
		xfer(1'b1, CLR, 32'h7);
		rd(RAW, 32'h0);
		for (int k = 0; k < 3; k++) begin
			ev(3'(1 << k));
			rd(MSK, 32'((2 << k) - 1));
		end
		chk({31'h0, irq}, 32'h1);
		xfer(1'b1, LIM, 32'h0800_0100);
		xfer(1'b1, CTL, 32'h7);
		rs(4'h5, 12'h800, 1'b0);
		rs(4'h5, 12'h100, 1'b0);
		rd(RAW, 32'h7);
		rs(4'h5, 12'h801, 1'b0);
		rs(4'h3, 12'h0ff, 1'b0);
		rd(RAW, 32'h0003_0007);
		rd(CTL, 32'h0503_0007);
		xfer(1'b1, CLR, ALL);
		rd(RAW, 32'h0);
		chk({31'h0, irq}, 32'h0);
		xfer(1'b1, CTL, 32'h0000_0202);
		rs(4'h4, 12'hfff, 1'b0);
		rs(4'h2, 12'h000, 1'b0);
		rd(RAW, 32'h0);
		rs(4'h2, 12'hfff, 1'b0);
		rs(4'h1, 12'h400, 1'b1);
		rd(MSK, 32'h0102_0000);
		xfer(1'b1, CLR, 32'h1);
		ev(3'h1);
		rd(RAW, 32'h0102_0001);
		test_done;
	end
endmodule
